// *** core/pmsab_bank.sv ***
// status register bank with three instances and alert masking
// Contract
// - status bits latch on event, held until cleared
// - three instances: direct, page 00h, page 01h
// - plain byte/word access reaches direct instance
// - fan status direct only, read and cleared
// - status events drive alert through instance masks
// - mask 0 passes event, mask 1 blocks
// - masks reset to 1, three page-01h exceptions
// - word low byte: off, ioc, vin uv, temp, cml
// - word high byte: vout, iout, input, fans summaries
// - input status bit layout 5,4,3,1,0
// - input undervoltage latches for any duration
// - all fans ORed into one fault, one warning
// - temperature reads return inlet, rectifier, pfc
// - write one clears only those bits
// - status word not writable, clears indirectly
// - same events set all; owner clears own
// - clear-faults wipes all status bits, masks kept, releases alert
`timescale 1ns/1ps
`include "pmsab_regs.svh"
module pmsab_bank
   import pmsab_pkg::*;
#(
   parameter int NFANS = 1
)
(
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire pmsab_cmd_t CMD,
   input wire pmsab_evt_t EVT,
   input wire logic [NFANS-1:0] FAN_FAULT,
   input wire logic [NFANS-1:0] FAN_WARN,
   input wire logic [15:0] TEMP_INLET,
   input wire logic [15:0] TEMP_SR,
   input wire logic [15:0] TEMP_PFC,
   input wire logic SMBALERT_N_I,
   output pmsab_rsp_t RSP,
   output logic SMBALERT_N_O,
   output logic SMBALERT_N_OE
);

localparam int NI = `PMSAB_NINST;
localparam int NR = `PMSAB_NREG;

// page 01h keeps three events unmasked from reset
localparam pmsab_bank_t BANK_RST = '{
   mask: {
      {`PMSAB_MASK_ALL, `PMSAB_MASK_ALL, `PMSAB_MASK_SEC_TEMP,
       `PMSAB_MASK_SEC_INPUT, `PMSAB_MASK_SEC_IOUT, `PMSAB_MASK_ALL},
      {NR{`PMSAB_MASK_ALL}},
      {NR{`PMSAB_MASK_ALL}}},
   rsp: '{rd_data: `PMSAB_ZERO16, rd_valid: 1'b0},
   alert: 1'b0};

pmsab_bank_t bank_q;
pmsab_bank_t bank_d;
pmsab_bank_arr_t stat;
pmsab_bank_arr_t w1c;
pmsab_bank_arr_t setv;
logic [NR-1:0][7:0] evset;
pmsab_inst_t inst;
logic [2:0] idx;
logic idx_ok;
logic [2:0] midx;
logic midx_ok;
logic wr_stat;
logic clr_all;
logic rd_req;
logic alert_raw;

////////////////////////////////////////////////////////////////////////////////
// instance and register decode

function automatic logic [3:0] decode_reg(input logic [7:0] code);
   logic [3:0] r;
   r = 4'h0;
   if (code == `PMSAB_CMD_VOUT)
      r = {1'b1, `PMSAB_R_VOUT};
   else if (code == `PMSAB_CMD_IOUT)
      r = {1'b1, `PMSAB_R_IOUT};
   else if (code == `PMSAB_CMD_INPUT)
      r = {1'b1, `PMSAB_R_INPUT};
   else if (code == `PMSAB_CMD_TEMP)
      r = {1'b1, `PMSAB_R_TEMP};
   else if (code == `PMSAB_CMD_CML)
      r = {1'b1, `PMSAB_R_CML};
   else if (code == `PMSAB_CMD_FAN)
      r = {1'b1, `PMSAB_R_FAN};
   return r;
endfunction

always_comb
begin
   // unpaged access lands on the direct instance
   if (!CMD.paged)
      inst = PMSAB_INST_DIRECT;
   else if (CMD.page == `PMSAB_PAGE_BMC)
      inst = PMSAB_INST_BMC;
   else if (CMD.page == `PMSAB_PAGE_SEC)
      inst = PMSAB_INST_SEC;
   else
      inst = PMSAB_INST_NONE;
   {idx_ok, idx} = decode_reg(CMD.code);
   {midx_ok, midx} = decode_reg(CMD.wdata[7:0]);
   // fan status has no paged copy, so paged fan access is dropped
   if (idx == `PMSAB_R_FAN && inst != PMSAB_INST_DIRECT)
      idx_ok = 1'b0;
   if (midx == `PMSAB_R_FAN && inst != PMSAB_INST_DIRECT)
      midx_ok = 1'b0;
end

// the status word has no write path at all
assign wr_stat = CMD.valid && CMD.write && idx_ok && inst != PMSAB_INST_NONE;
assign clr_all = CMD.valid && CMD.write && CMD.code == `PMSAB_CMD_CLEAR;
assign rd_req = CMD.valid && !CMD.write;

////////////////////////////////////////////////////////////////////////////////
// event mapping onto status bits

always_comb
begin
   evset = '0;
   evset[`PMSAB_R_VOUT][`PMSAB_B_VOUT_OV] = EVT.vout_ov;
   evset[`PMSAB_R_VOUT][`PMSAB_B_VOUT_UV] = EVT.vout_uv;
   evset[`PMSAB_R_IOUT][`PMSAB_B_IOUT_OCF] = EVT.iout_ocf;
   evset[`PMSAB_R_IOUT][`PMSAB_B_IOUT_OCW] = EVT.iout_ocw;
   evset[`PMSAB_R_IOUT][`PMSAB_B_POUT_OPF] = EVT.pout_opf;
   evset[`PMSAB_R_IOUT][`PMSAB_B_POUT_OPW] = EVT.pout_opw;
   evset[`PMSAB_R_INPUT][`PMSAB_B_VIN_UVW] = EVT.vin_uvw;
   // single-cycle dropout is enough; nothing filters it
   evset[`PMSAB_R_INPUT][`PMSAB_B_VIN_UVF] = EVT.vin_uvf;
   evset[`PMSAB_R_INPUT][`PMSAB_B_VIN_OFF] = EVT.vin_off;
   evset[`PMSAB_R_INPUT][`PMSAB_B_IIN_OCW] = EVT.iin_ocw;
   evset[`PMSAB_R_INPUT][`PMSAB_B_PIN_OPW] = EVT.pin_opw;
   evset[`PMSAB_R_TEMP][`PMSAB_B_OT_F] = EVT.ot_f;
   evset[`PMSAB_R_TEMP][`PMSAB_B_OT_W] = EVT.ot_w;
   evset[`PMSAB_R_CML][`PMSAB_B_CML_CMD] = EVT.cml_cmd;
   evset[`PMSAB_R_CML][`PMSAB_B_CML_DATA] = EVT.cml_data;
   evset[`PMSAB_R_CML][`PMSAB_B_CML_PEC] = EVT.cml_pec;
   evset[`PMSAB_R_FAN][`PMSAB_B_FAN_F] = |FAN_FAULT;
   evset[`PMSAB_R_FAN][`PMSAB_B_FAN_W] = |FAN_WARN;
end

////////////////////////////////////////////////////////////////////////////////
// status instances

genvar gi;
genvar gr;
generate
   for (gi = 0; gi < NI; gi++)
   begin : g_inst
      for (gr = 0; gr < NR; gr++)
      begin : g_reg
         localparam logic [2:0] RIDX = 3'(gr);
         localparam logic [1:0] IIDX = 2'(gi);
         localparam logic LIVE = (RIDX != `PMSAB_R_FAN) || (gi == 0);
         // every live copy sees the same events
         assign setv[gi][gr] = LIVE ? evset[gr] : `PMSAB_ZERO8;
         // only the owning page may clear its copy
         assign w1c[gi][gr] = (wr_stat && inst == pmsab_inst_t'(IIDX) && idx == RIDX)
            ? CMD.wdata[7:0] : `PMSAB_ZERO8;
         pmsab_status_reg u_sreg (
            .clk(CLOCK),
            .rst(SYS_RST),
            .set(setv[gi][gr]),
            .w1c(w1c[gi][gr]),
            .clr_all(clr_all),
            .q(stat[gi][gr])
         );
      end
   end
endgenerate

pmsab_alert_gen u_alert (
   .stat(stat),
   .mask(bank_q.mask),
   .alert(alert_raw)
);

////////////////////////////////////////////////////////////////////////////////
// status word and read mux

function automatic logic [15:0] word_of(input logic [1:0] i);
   logic [15:0] w;
   w = `PMSAB_ZERO16;
   w[`PMSAB_W_OFF] = EVT.unit_off;
   w[`PMSAB_W_IOC] = stat[i][`PMSAB_R_IOUT][`PMSAB_B_IOUT_OCF];
   w[`PMSAB_W_VUV] = stat[i][`PMSAB_R_INPUT][`PMSAB_B_VIN_UVF];
   w[`PMSAB_W_TEMP] = |stat[i][`PMSAB_R_TEMP];
   w[`PMSAB_W_CML] = |stat[i][`PMSAB_R_CML];
   w[`PMSAB_W_VOUT] = |stat[i][`PMSAB_R_VOUT];
   w[`PMSAB_W_IOUT] = |stat[i][`PMSAB_R_IOUT];
   w[`PMSAB_W_INPUT] = |stat[i][`PMSAB_R_INPUT];
   // fans exist once, every word reports the shared copy
   w[`PMSAB_W_FAN] = |stat[0][`PMSAB_R_FAN];
   return w;
endfunction

always_comb
begin
   bank_d = bank_q;
   bank_d.rsp.rd_valid = rd_req;
   bank_d.rsp.rd_data = `PMSAB_ZERO16;
   if (rd_req && inst != PMSAB_INST_NONE)
   begin
      if (CMD.code == `PMSAB_CMD_WORD)
         bank_d.rsp.rd_data = word_of(inst);
      else if (idx_ok)
         bank_d.rsp.rd_data = {`PMSAB_ZERO8, stat[inst][idx]};
      else if (CMD.code == `PMSAB_CMD_T1)
         bank_d.rsp.rd_data = TEMP_INLET;
      else if (CMD.code == `PMSAB_CMD_T2)
         bank_d.rsp.rd_data = TEMP_SR;
      else if (CMD.code == `PMSAB_CMD_T3)
         bank_d.rsp.rd_data = TEMP_PFC;
      else if (CMD.code == `PMSAB_CMD_MASK && midx_ok)
         bank_d.rsp.rd_data = {`PMSAB_ZERO8, bank_q.mask[inst][midx]};
   end
   if (CMD.valid && CMD.write && CMD.code == `PMSAB_CMD_MASK && midx_ok
       && inst != PMSAB_INST_NONE)
      bank_d.mask[inst][midx] = CMD.wdata[15:8];
   // clear-faults drops the alert at once, not a cycle later
   bank_d.alert = clr_all ? 1'b0 : alert_raw;
end

always_ff @(posedge CLOCK or posedge SYS_RST)
begin
   if (SYS_RST)
      bank_q <= BANK_RST;
   else
      bank_q <= bank_d;
end

assign RSP = bank_q.rsp;
// open drain: pull low only, release otherwise
assign SMBALERT_N_O = 1'b0;
assign SMBALERT_N_OE = bank_q.alert;

////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge CLOCK); endclocking
default disable iff (SYS_RST);

sequence s_clear;
   clr_all && EVT == '0 && FAN_FAULT == '0 && FAN_WARN == '0;
endsequence
sequence s_quiet;
   EVT == '0 && FAN_FAULT == '0 && FAN_WARN == '0;
endsequence
sequence s_rd(logic [7:0] c);
   rd_req && CMD.code == c && inst != PMSAB_INST_NONE;
endsequence

chk_clear_release: assert property (s_clear ##1 s_quiet |->
   ##1 (!SMBALERT_N_OE && stat == '0) ##1 !SMBALERT_N_OE)
   else $error("clear-faults left status or alert");
chk_temp_inlet: assert property (s_rd(`PMSAB_CMD_T1) |=>
   RSP.rd_valid && RSP.rd_data == $past(TEMP_INLET))
   else $error("inlet temperature read wrong");
chk_temp_sr: assert property (s_rd(`PMSAB_CMD_T2) |=>
   RSP.rd_valid && RSP.rd_data == $past(TEMP_SR))
   else $error("rectifier temperature read wrong");
chk_temp_pfc: assert property (s_rd(`PMSAB_CMD_T3) |=>
   RSP.rd_valid && RSP.rd_data == $past(TEMP_PFC))
   else $error("pfc temperature read wrong");
chk_word_input: assert property (s_rd(`PMSAB_CMD_WORD) ##0 !CMD.paged |=>
   RSP.rd_data[`PMSAB_W_INPUT] == $past(|stat[0][`PMSAB_R_INPUT]))
   else $error("input summary mismatch");
chk_word_ocf: assert property (s_rd(`PMSAB_CMD_WORD) ##0 inst == PMSAB_INST_BMC |=>
   RSP.rd_data[`PMSAB_W_IOC] == $past(stat[1][`PMSAB_R_IOUT][`PMSAB_B_IOUT_OCF]))
   else $error("overcurrent summary mismatch");
chk_fan_or: assert property (|FAN_FAULT |=> stat[0][`PMSAB_R_FAN][`PMSAB_B_FAN_F])
   else $error("fan fault not merged");
chk_fan_paged: assert property (CMD.valid && CMD.write && CMD.paged
   && CMD.code == `PMSAB_CMD_FAN |=> ($past(stat[0]) & ~stat[0]) == '0)
   else $error("paged write cleared fan status");
chk_own_clear: assert property (CMD.valid && CMD.write && inst == PMSAB_INST_BMC
   && CMD.code != `PMSAB_CMD_CLEAR |=> ($past(stat[0]) & ~stat[0]) == '0)
   else $error("page write cleared direct instance");
chk_uv_latch: assert property (EVT.vin_uvf |=> stat[0][`PMSAB_R_INPUT][`PMSAB_B_VIN_UVF]
   && stat[1][`PMSAB_R_INPUT][`PMSAB_B_VIN_UVF] && stat[2][`PMSAB_R_INPUT][`PMSAB_B_VIN_UVF])
   else $error("input undervoltage not latched");
chk_mask_pass: assert property (stat[0][`PMSAB_R_TEMP][`PMSAB_B_OT_F]
   && !bank_q.mask[0][`PMSAB_R_TEMP][`PMSAB_B_OT_F] && !clr_all |=> SMBALERT_N_OE)
   else $error("unmasked event did not alert");
chk_word_iout: assert property (s_rd(`PMSAB_CMD_WORD) ##0 inst == PMSAB_INST_SEC |=>
   RSP.rd_data[`PMSAB_W_IOUT] == $past(|stat[2][`PMSAB_R_IOUT]))
   else $error("output current summary mismatch");
chk_clear_now: assert property (clr_all |=> !SMBALERT_N_OE)
   else $error("clear-faults kept the alert");
// a refused or foreign write must leave the other copies intact
chk_word_ro: assert property (CMD.valid && CMD.write && CMD.code == `PMSAB_CMD_WORD
   |=> ($past(stat) & ~stat) == '0)
   else $error("status word write cleared status");
chk_sec_clear: assert property (CMD.valid && CMD.write && inst == PMSAB_INST_SEC
   && CMD.code != `PMSAB_CMD_CLEAR |=> ($past(stat[1]) & ~stat[1]) == '0)
   else $error("secondary write cleared page 00h copy");
chk_page_none: assert property (CMD.valid && CMD.write && inst == PMSAB_INST_NONE
   && CMD.code != `PMSAB_CMD_CLEAR |=> ($past(stat) & ~stat) == '0)
   else $error("unknown page cleared status");
chk_rsp_idle: assert property (!rd_req |=> !RSP.rd_valid && RSP.rd_data == '0)
   else $error("read answer outside a read");

endmodule // pmsab_bank

// *** core/pmsab_regs.svh ***
// command codes, bit positions and reset values of the status bank
`ifndef PMSAB_REGS_SVH
`define PMSAB_REGS_SVH

`define PMSAB_NINST 3
`define PMSAB_NREG 6

`define PMSAB_CMD_CLEAR 8'h03
`define PMSAB_CMD_MASK 8'h1b
`define PMSAB_CMD_WORD 8'h79
`define PMSAB_CMD_VOUT 8'h7a
`define PMSAB_CMD_IOUT 8'h7b
`define PMSAB_CMD_INPUT 8'h7c
`define PMSAB_CMD_TEMP 8'h7d
`define PMSAB_CMD_CML 8'h7e
`define PMSAB_CMD_FAN 8'h81
`define PMSAB_CMD_T1 8'h8d
`define PMSAB_CMD_T2 8'h8e
`define PMSAB_CMD_T3 8'h8f
`define PMSAB_PAGE_BMC 8'h00
`define PMSAB_PAGE_SEC 8'h01

`define PMSAB_R_VOUT 3'h0
`define PMSAB_R_IOUT 3'h1
`define PMSAB_R_INPUT 3'h2
`define PMSAB_R_TEMP 3'h3
`define PMSAB_R_CML 3'h4
`define PMSAB_R_FAN 3'h5

`define PMSAB_B_VOUT_OV 7
`define PMSAB_B_VOUT_UV 4
`define PMSAB_B_IOUT_OCF 7
`define PMSAB_B_IOUT_OCW 5
`define PMSAB_B_POUT_OPF 1
`define PMSAB_B_POUT_OPW 0
`define PMSAB_B_VIN_UVW 5
`define PMSAB_B_VIN_UVF 4
`define PMSAB_B_VIN_OFF 3
`define PMSAB_B_IIN_OCW 1
`define PMSAB_B_PIN_OPW 0
`define PMSAB_B_OT_F 7
`define PMSAB_B_OT_W 6
`define PMSAB_B_CML_CMD 7
`define PMSAB_B_CML_DATA 6
`define PMSAB_B_CML_PEC 5
`define PMSAB_B_FAN_F 7
`define PMSAB_B_FAN_W 5

`define PMSAB_W_OFF 6
`define PMSAB_W_IOC 4
`define PMSAB_W_VUV 3
`define PMSAB_W_TEMP 2
`define PMSAB_W_CML 1
`define PMSAB_W_VOUT 15
`define PMSAB_W_IOUT 14
`define PMSAB_W_INPUT 13
`define PMSAB_W_FAN 10

`define PMSAB_MASK_ALL 8'hff
`define PMSAB_MASK_SEC_IOUT 8'hdf
`define PMSAB_MASK_SEC_INPUT 8'hef
`define PMSAB_MASK_SEC_TEMP 8'hbf
`define PMSAB_ZERO8 8'h00
`define PMSAB_ZERO16 16'h0000

`endif

// *** core/pmsab_pkg.sv ***
// types shared by the status bank modules
package pmsab_pkg;
`include "pmsab_regs.svh"

typedef logic [7:0] pmsab_byte_t;

typedef enum logic [1:0] {
   PMSAB_INST_DIRECT = 2'b00,
   PMSAB_INST_BMC = 2'b01,
   PMSAB_INST_SEC = 2'b10,
   PMSAB_INST_NONE = 2'b11
} pmsab_inst_t;

typedef struct packed {
   logic valid;
   logic write;
   logic paged;
   logic [7:0] page;
   logic [7:0] code;
   logic [15:0] wdata;
} pmsab_cmd_t;

typedef struct packed {
   logic [15:0] rd_data;
   logic rd_valid;
} pmsab_rsp_t;

typedef struct packed {
   logic unit_off;
   logic vout_ov;
   logic vout_uv;
   logic iout_ocf;
   logic iout_ocw;
   logic pout_opf;
   logic pout_opw;
   logic vin_uvw;
   logic vin_uvf;
   logic vin_off;
   logic iin_ocw;
   logic pin_opw;
   logic ot_f;
   logic ot_w;
   logic cml_cmd;
   logic cml_data;
   logic cml_pec;
} pmsab_evt_t;

typedef struct packed {
   pmsab_byte_t bits;
} pmsab_sreg_t;

typedef logic [`PMSAB_NINST-1:0][`PMSAB_NREG-1:0][7:0] pmsab_bank_arr_t;

typedef struct packed {
   pmsab_bank_arr_t mask;
   pmsab_rsp_t rsp;
   logic alert;
} pmsab_bank_t;

endpackage

// *** core/pmsab_status_reg.sv ***
// one sticky write-one-to-clear status byte
`timescale 1ns/1ps
`include "pmsab_regs.svh"
module pmsab_status_reg
   import pmsab_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] set,
   input wire logic [7:0] w1c,
   input wire logic clr_all,
   output logic [7:0] q
);

pmsab_sreg_t state_q;
pmsab_sreg_t state_d;
logic [7:0] clr;

always_comb
begin
   clr = w1c | {8{clr_all}};
   // set after clear so an event in the clearing cycle survives
   state_d.bits = (state_q.bits & ~clr) | set;
end

always_ff @(posedge clk or posedge rst)
begin
   if (rst)
      state_q <= '{bits: `PMSAB_ZERO8};
   else
      state_q <= state_d;
end

assign q = state_q.bits;

////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (rst);

chk_set_wins: assert property (set != '0 |=> (q & $past(set)) == $past(set))
   else $error("status set event lost");
chk_bit_hold: assert property (##1 ($past(q) & ~$past(clr) & ~q) == '0)
   else $error("status bit dropped without clear");
chk_w1c_exact: assert property (set == '0 && !clr_all |=> q == ($past(q) & ~$past(w1c)))
   else $error("write-one-to-clear touched wrong bits");

endmodule // pmsab_status_reg

// *** core/pmsab_alert_gen.sv ***
// combines unmasked status bits of every instance into one alert request
`timescale 1ns/1ps
`include "pmsab_regs.svh"
module pmsab_alert_gen
   import pmsab_pkg::*;
(
   input wire pmsab_bank_arr_t stat,
   input wire pmsab_bank_arr_t mask,
   output logic alert
);

localparam int NENT = `PMSAB_NINST * `PMSAB_NREG;
logic [NENT-1:0] hit;

genvar ge;
generate
   for (ge = 0; ge < NENT; ge++)
   begin : g_ent
      // mask bit 0 lets the event through, 1 blocks it
      assign hit[ge] = |(stat[ge / `PMSAB_NREG][ge % `PMSAB_NREG]
         & ~mask[ge / `PMSAB_NREG][ge % `PMSAB_NREG]);
   end
endgenerate

assign alert = |hit;

endmodule // pmsab_alert_gen

// *** tb/pmsab_host.sv ***
// bus master model issuing one status bank request at a time
`timescale 1ns/1ps
module pmsab_host
   import pmsab_pkg::*;
(
   input wire logic clk,
   input wire pmsab_rsp_t rsp,
   output pmsab_cmd_t cmd
);
////////////////////////////////////////////////////////////////
initial cmd = '0;
// request held for the taking edge only, as there is no ready
// the answer stands one cycle, so it is taken just after that edge
// clears carry ones only on the bits to drop
task automatic xfer(input logic w, input logic pg, input logic [7:0] page,
   input logic [7:0] code, input logic [15:0] wd, output pmsab_rsp_t r);
   @(posedge clk);
   cmd <= '{1'b1, w, pg, page, code, wd};
   @(posedge clk);
   cmd <= '0;
   #1;
   r = rsp;
endtask
endmodule // pmsab_host

// *** tb/testbench.sv ***
// self-checking bench for the status bank against an integer model
`timescale 1ns/1ps
module testbench
   import pmsab_pkg::*;
;
////////////////////////////////////////////////////////////////
localparam int NF = 2;
logic CLOCK = 1'b0;
logic SYS_RST = 1'b1;
pmsab_cmd_t cmd;
pmsab_evt_t evt = '0;
logic [NF-1:0] ff = '0;
logic [NF-1:0] fw = '0;
logic [15:0] t1 = 16'h0;
logic [15:0] t2 = 16'h0;
logic [15:0] t3 = 16'h0;
pmsab_rsp_t rsp;
pmsab_rsp_t r;
logic oe;
logic pin_o;
logic pin;
int fail_count = 0;
int total_checks = 0;
int cyc = 0;
int st[3][6];
int mk[3][6];
// event bit to reg*8+bit; unit_off is live, never latched
int map[17] = '{37, 38, 39, 30, 31, 16, 17, 19, 20, 21, 8, 9, 13, 15, 4, 7, -1};

pmsab_bank #(.NFANS(NF)) pmsab_bank_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CMD(cmd),
   .EVT(evt), .FAN_FAULT(ff), .FAN_WARN(fw), .TEMP_INLET(t1), .TEMP_SR(t2),
   .TEMP_PFC(t3), .SMBALERT_N_I(pin), .RSP(rsp), .SMBALERT_N_O(pin_o),
   .SMBALERT_N_OE(oe));
pmsab_host pmsab_host_inst (.clk(CLOCK), .rsp(rsp), .cmd(cmd));
// pulled up when nobody drives the alert line
assign pin = oe ? pin_o : 1'b1;

////////////////////////////////////////////////////////////////
initial forever #10 CLOCK = ~CLOCK;

always @(posedge CLOCK)
begin
   cyc <= cyc + 1;
   if (cyc == 20000)
   begin
      fail_count++;
      wrap_up();
   end
end

////////////////////////////////////////////////////////////////
task automatic wrap_up();
   $display("checks %0d mismatches %0d", total_checks, fail_count);
   if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
   else
      $display("TESTS FAILED");
   $finish;
endtask

task automatic chk(input logic [15:0] got, input int exp, input string what);
   total_checks++;
   if (got !== exp[15:0])
   begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp[15:0]);
   end
endtask

function automatic logic [7:0] cd(input int j);
   return j == 5 ? 8'h81 : 8'h7a + 8'(j);
endfunction

// fans come from the single direct copy for every instance
function automatic int word(input int i);
   return (evt.unit_off << 6) | (st[i][1] & 128) >> 3 | ((st[i][2] >> 4 & 1) << 3)
      | (st[i][3] != 0) << 2 | (st[i][4] != 0) << 1 | (st[i][0] != 0) << 15
      | (st[i][1] != 0) << 14 | (st[i][2] != 0) << 13 | (st[0][5] != 0) << 10;
endfunction

function automatic logic alert_exp();
   alert_exp = 1'b0;
   foreach (st[i, j])
      if ((st[i][j] & ~mk[i][j] & 255) != 0)
         alert_exp = 1'b1;
endfunction

// instance 3 maps to page 02h, which the bank must ignore
task automatic wr(input int i, input logic [7:0] c, input logic [15:0] wd);
   pmsab_host_inst.xfer(1'b1, i != 0, 8'(i - 1), c, wd, r);
endtask

task automatic rd(input int i, input logic [7:0] c, input logic [15:0] wd, input int exp);
   pmsab_host_inst.xfer(1'b0, i != 0, 8'(i - 1), c, wd, r);
   chk({15'h0, r.rd_valid}, 1, "read strobe");
   chk(r.rd_data, exp, "read data");
endtask

// one-cycle events, so momentary dropouts must still latch
task automatic pulse(input pmsab_evt_t e, input logic [NF-1:0] f, input logic [NF-1:0] w);
   @(posedge CLOCK);
   evt <= e;
   ff <= f;
   fw <= w;
   @(posedge CLOCK);
   evt <= '0;
   ff <= '0;
   fw <= '0;
   for (int b = 0; b < 17; b++)
      if (e[b] && map[b] >= 0)
         for (int i = 0; i < 3; i++)
            st[i][map[b] / 8] |= 1 << map[b] % 8;
   if (|f)
      st[0][5] |= 128;
   if (|w)
      st[0][5] |= 32;
endtask

task automatic rd_all();
   for (int i = 0; i < 3; i++)
   begin
      for (int j = 0; j < 5; j++)
         rd(i, cd(j), 16'h0, st[i][j]);
      rd(i, 8'h79, 16'h0, word(i));
   end
   rd(0, 8'h81, 16'h0, st[0][5]);
   rd(1, 8'h81, 16'h0, 0);
   chk(oe, alert_exp(), "alert");
   chk(pin, !alert_exp(), "alert pin");
endtask

////////////////////////////////////////////////////////////////
initial
begin
   int v;
   int m;
   void'($urandom(32'hb503));
   foreach (st[i, j])
   begin
      st[i][j] = 0;
      mk[i][j] = 255;
   end
   mk[2][1] = 'hdf;
   mk[2][2] = 'hef;
   mk[2][3] = 'hbf;
   t1 = 16'($urandom);
   t2 = 16'($urandom);
   t3 = 16'($urandom);
   repeat (16) @(posedge CLOCK);
   SYS_RST <= 1'b0;
   for (int i = 0; i < 3; i++)
      for (int j = 0; j < 6; j++)
         if (j < 5 || i == 0)
            rd(i, 8'h1b, {8'h0, cd(j)}, mk[i][j]);
   rd_all();
   for (int b = 0; b < 16; b++)
   begin
      pulse(pmsab_evt_t'(17'h1 << b), '0, '0);
      rd_all();
   end
   pulse('0, 2'b10, 2'b01);
   rd_all();
   // random events, clears and masks from every owner
   repeat (4)
   begin
      pulse(pmsab_evt_t'($urandom & 32'h0ffff), NF'($urandom), NF'($urandom));
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 6; j++)
         begin
            v = $urandom & 255;
            m = $urandom & 255;
            wr(i, cd(j), 16'(v));
            wr(i, 8'h1b, {8'(m), cd(j)});
            if (j < 5 || i == 0)
            begin
               st[i][j] &= ~v;
               mk[i][j] = m;
               rd(i, 8'h1b, {8'h0, cd(j)}, m);
            end
         end
      wr(1, 8'h79, 16'hffff);
      wr(3, 8'h7c, 16'h00ff);
      rd_all();
   end
   pulse(pmsab_evt_t'($urandom & 32'h0ffff), 2'b01, 2'b01);
   wr(2, 8'h03, 16'h0);
   foreach (st[i, j])
      st[i][j] = 0;
   rd_all();
   @(posedge CLOCK);
   evt <= 17'h10000;
   rd(1, 8'h79, 16'h0, 64);
   evt <= '0;
   rd(0, 8'h8d, 16'h0, t1);
   rd(1, 8'h8e, 16'h0, t2);
   rd(2, 8'h8f, 16'h0, t3);
   wrap_up();
end
endmodule // testbench
